// [rtl/flbc_params.svh]
// Purpose: Constants of the four-level block codec.
// Assumes: Included by the codec core and its testbench.
// Notes:   Offsets, field positions, codes and counts.
`ifndef FLBC_PARAMS_SVH
`define FLBC_PARAMS_SVH

// ****************************************
// Clocking
// ****************************************
`define FLBC_CLK_HZ        40000000
`define FLBC_SYM_RATE_HZ   4800

// ****************************************
// Block geometry
// ****************************************
`define FLBC_BLK_BYTES     12
`define FLBC_CRC_BYTES     10
`define FLBC_DATA_TRIBITS  32
`define FLBC_FEC_SYMS      66
`define FLBC_RAW_SYMS      48
`define FLBC_RAW_PAIRS     24
`define FLBC_IL_ROWS       6
`define FLBC_IL_COLS       11
`define FLBC_SYNC_BITS     48

// ****************************************
// CRC
// ****************************************
`define FLBC_CRC_INIT      16'hFFFF
`define FLBC_CRC_POLY      16'h1021

// ****************************************
// Host select codes
// ****************************************
`define FLBC_SEL_DATA      2'h0
`define FLBC_SEL_CMD       2'h1
`define FLBC_SEL_MODE      2'h2
`define FLBC_SEL_CTL       2'h3

// ****************************************
// Task codes, command bits [2:0]
// ****************************************
`define FLBC_TASK_NULL     3'h0
`define FLBC_TASK_RESET    3'h1
`define FLBC_TASK_HDR      3'h2
`define FLBC_TASK_INT      3'h3
`define FLBC_TASK_LAST     3'h4
`define FLBC_TASK_RAW      3'h5
`define FLBC_TASK_SEARCH   3'h6

// ****************************************
// Register fields and reset values
// ****************************************
`define FLBC_ST_BFREE      7
`define FLBC_ST_CRCERR     6
`define FLBC_ST_SYNC       5
`define FLBC_ST_TXBUSY     4
`define FLBC_MODE_TX       0
`define FLBC_CTL_IL        0
`define FLBC_MODE_RST      8'h00
`define FLBC_CTL_RST       8'h01
`define FLBC_DQ_MAX        8'hFF

`endif

// [rtl/flbc_pkg.sv]
// Purpose: Types of the four-level block codec.
// Assumes: Nothing.
// Notes:   Level codes ordered from lowest to highest deviation.
package flbc_pkg;

  typedef enum logic [1:0] {
    LVL_M3 = 2'h0,
    LVL_M1 = 2'h1,
    LVL_P1 = 2'h2,
    LVL_P3 = 2'h3
  } flbc_lvl_t;

  typedef enum logic [5:0] {
    ST_IDLE   = 6'h01,
    ST_CRC    = 6'h02,
    ST_ENC    = 6'h04,
    ST_SEARCH = 6'h08,
    ST_GATHER = 6'h10,
    ST_DEC    = 6'h20
  } flbc_state_t;

endpackage

// [rtl/flbc_symmap.sv]
// Purpose: Bit pair to four-level symbol map, both directions.
// Assumes: Pure combinational, one instance per direction.
// Notes:   Gray-like map keeps one bit error per level slip.
module flbc_symmap
  import flbc_pkg::*;
(
  // Pair to level
  input  wire logic [1:0] i_dibit,
  output flbc_lvl_t       o_lvl,
  // Level to pair
  input  wire flbc_lvl_t  i_lvl,
  output logic      [1:0] o_dibit
);

  always_comb begin
    unique case (i_dibit)
      2'h3: o_lvl = LVL_P3;
      2'h2: o_lvl = LVL_P1;
      2'h0: o_lvl = LVL_M1;
      2'h1: o_lvl = LVL_M3;
    endcase
  end

  always_comb begin
    unique case (i_lvl)
      LVL_P3: o_dibit = 2'h3;
      LVL_P1: o_dibit = 2'h2;
      LVL_M1: o_dibit = 2'h0;
      LVL_M3: o_dibit = 2'h1;
    endcase
  end

endmodule

// [rtl/flbc_core.sv]
// Purpose: Block formatter/deformatter of a four-level FSK modem.
// Assumes: Host strobes synchronous to i_clk, one access per strobe.
// Notes:   One block in flight each way; symbols enter/leave as levels.
// Function
// - Direct mode maps pairs 11,10,00,01 to +3,+1,-1,-3 and back.
// - Direct mode turns each byte into four symbols and back.
// - FEC mode codes each three bits into two symbols.
// - A twelve byte block splits into thirty-two tri-bits.
// - One all-zero tri-bit is appended, giving thirty-three.
// - Trellis coder turns thirty-three tri-bits into sixty-six symbols.
// - Receiver decodes sixty-six symbols back to twelve bytes.
// - Frame is preamble with sync patterns, then header/middle/last.
// - Header block carries its own CRC over itself alone.
// - Middle blocks carry data; one CRC ends the last block.
// - Host loads raw bytes then commands; device adds CRC, FEC, interleave.
// - Receive task gathers, de-interleaves, decodes, checks, fills buffer.
// - Receiver searches and locks onto the frame sync pattern.
// - Unformatted blocks go without CRC, FEC or interleaving.
// - Host services once per block; device does all symbol work.
// - Four write registers overlaid by three read, two select bits.
// - One code reaches the buffer both ways; another command/status.
// - Buffer auto-sequences; writes ignored in receive, reads in send.
// - Symbols interleaved per block on send, de-interleaved on receive.
`include "flbc_params.svh"
module flbc_core
  import flbc_pkg::*;
#(
  parameter int          SYM_DIV    = `FLBC_CLK_HZ / `FLBC_SYM_RATE_HZ,
  parameter logic [47:0] SYNC_PATTN = 48'h0123_4567_89AB
) (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_srst,
  // Host port
  input  wire logic       i_cs_n,
  input  wire logic       i_rd_n,
  input  wire logic       i_wr_n,
  input  wire logic [1:0] i_addr,
  input  wire logic [7:0] i_data,
  output logic      [7:0] o_data,
  output logic            o_data_oe,
  // Transmit symbols
  output logic      [1:0] o_sym_lvl,
  output logic            o_sym_stb,
  output logic            o_tx_active,
  // Receive symbols
  input  wire logic [1:0] i_sym_lvl,
  input  wire logic       i_sym_stb
);

  // ****************************************
  // Declarations
  // ****************************************
  flbc_state_t state_q;
  logic [7:0]  buf_q [`FLBC_BLK_BYTES];
  logic [1:0]  sym_q [`FLBC_FEC_SYMS];
  logic [95:0] buf_bits;
  logic [95:0] dec_bits_q;
  logic [95:0] crc_bits;
  logic [7:0]  mode_q, ctl_q, dq_q, rd_data_q;
  logic [2:0]  task_q, trel_q, tribit;
  logic        bfree_q, crc_err_q, sync_q, raw_q;
  logic        wr_act_q, rd_act_q, wr_go, rd_go, tx_mode;
  logic [3:0]  hptr_q;
  logic [5:0]  cnt_q;
  logic [6:0]  tx_left_q, seq_k_q, pos, need;
  logic [2:0]  il_row_q;
  logic [3:0]  il_col_q;
  logic [15:0] div_cnt_q, acc_q, crc_hdr, crc_run12, crc_run10;
  logic        sym_en, task_go, data_wr, data_rd, pos_adv;
  logic [47:0] win_q;
  logic [1:0]  rx_dibit;
  flbc_lvl_t   tx_lvl;
  logic [6:0]  idx0, idx1;
  logic [2:0]  wtask;

  function automatic logic [15:0] crc_calc(input logic [15:0] seed,
                                           input logic [95:0] bits,
                                           input int nbytes);
    logic [15:0] c;
    c = seed;
    for (int i = 0; i < 96; i++) begin
      if (i < 8 * nbytes) begin
        if (c[15] ^ bits[95-i])
          c = {c[14:0], 1'b0} ^ `FLBC_CRC_POLY;
        else
          c = {c[14:0], 1'b0};
      end
    end
    return c;
  endfunction

  // ****************************************
  // Host decode
  // ****************************************
  assign tx_mode = mode_q[`FLBC_MODE_TX];
  assign wr_go   = ~i_cs_n & ~i_wr_n & ~wr_act_q;
  assign rd_go   = ~i_cs_n & ~i_rd_n & ~rd_act_q;
  assign wtask   = i_data[2:0];
  assign task_go = wr_go && i_addr == `FLBC_SEL_CMD
                   && wtask != `FLBC_TASK_NULL
                   && (bfree_q || wtask == `FLBC_TASK_RESET);
  assign data_wr = wr_go && i_addr == `FLBC_SEL_DATA && tx_mode
                   && bfree_q && hptr_q < 4'(`FLBC_BLK_BYTES);
  assign data_rd = rd_go && i_addr == `FLBC_SEL_DATA && !tx_mode
                   && bfree_q && hptr_q < 4'(`FLBC_BLK_BYTES);
  assign o_data    = rd_data_q;
  assign o_data_oe = ~i_cs_n & ~i_rd_n;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      wr_act_q <= 1'b0;
      rd_act_q <= 1'b0;
    end else begin
      wr_act_q <= ~i_cs_n & ~i_wr_n;
      rd_act_q <= ~i_cs_n & ~i_rd_n;
    end
  end

  // Write-only registers overlaid on read-only ones
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      mode_q    <= `FLBC_MODE_RST;
      ctl_q     <= `FLBC_CTL_RST;
      rd_data_q <= 8'h00;
    end else begin
      if (wr_go && i_addr == `FLBC_SEL_MODE)
        mode_q <= i_data;
      if (wr_go && i_addr == `FLBC_SEL_CTL)
        ctl_q <= i_data;
      if (rd_go) begin
        unique case (i_addr)
          `FLBC_SEL_DATA: rd_data_q <= data_rd ? buf_q[hptr_q] : 8'h00;
          `FLBC_SEL_CMD:  rd_data_q <= {bfree_q, crc_err_q, sync_q,
                                        o_tx_active, 4'h0};
          `FLBC_SEL_MODE: rd_data_q <= dq_q;
          `FLBC_SEL_CTL:  rd_data_q <= 8'h00;
        endcase
      end
    end
  end

  // Single byte window onto the buffer
  always_ff @(posedge i_clk) begin
    // Mode change restarts the byte sequence for the other direction
    if (i_srst || task_go || (state_q == ST_CRC && !tx_mode)
        || (wr_go && i_addr == `FLBC_SEL_MODE))
      hptr_q <= 4'h0;
    else if (state_q == ST_ENC && cnt_q == 6'h00)
      hptr_q <= 4'h0;
    else if (data_wr || data_rd)
      hptr_q <= hptr_q + 4'h1;
  end

  // ****************************************
  // Shared CRC
  // ****************************************
  always_comb begin
    for (int i = 0; i < `FLBC_BLK_BYTES; i++)
      buf_bits[95-8*i -: 8] = buf_q[i];
  end
  assign crc_bits  = tx_mode ? buf_bits : dec_bits_q;
  assign crc_hdr   = crc_calc(`FLBC_CRC_INIT, crc_bits, `FLBC_CRC_BYTES);
  assign crc_run12 = crc_calc(acc_q, crc_bits, `FLBC_BLK_BYTES);
  assign crc_run10 = crc_calc(acc_q, crc_bits, `FLBC_CRC_BYTES);

  // ****************************************
  // Sequencer
  // ****************************************
  assign need = raw_q ? 7'(`FLBC_RAW_SYMS) : 7'(`FLBC_FEC_SYMS);

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state_q <= ST_IDLE;
      task_q  <= `FLBC_TASK_NULL;
      raw_q   <= 1'b0;
      bfree_q <= 1'b1;
      cnt_q   <= 6'h00;
    end else if (task_go) begin
      task_q  <= wtask;
      raw_q   <= wtask == `FLBC_TASK_RAW;
      bfree_q <= wtask == `FLBC_TASK_RESET;
      cnt_q   <= 6'h00;
      if (wtask == `FLBC_TASK_RESET)
        state_q <= ST_IDLE;
      else if (tx_mode)
        state_q <= (wtask == `FLBC_TASK_SEARCH) ? ST_IDLE : ST_CRC;
      else
        state_q <= (wtask == `FLBC_TASK_SEARCH) ? ST_SEARCH : ST_GATHER;
      if (tx_mode && wtask == `FLBC_TASK_SEARCH)
        bfree_q <= 1'b1;
    end else begin
      unique case (state_q)
        ST_IDLE: ;
        ST_CRC: begin
          // Send: wait for room; receive: block fully decoded
          if (!tx_mode || tx_left_q == 7'h00) begin
            state_q <= tx_mode ? ST_ENC : ST_IDLE;
            bfree_q <= !tx_mode;
          end
        end
        ST_ENC: begin
          cnt_q <= cnt_q + 6'h01;
          if (cnt_q == (raw_q ? 6'(`FLBC_RAW_PAIRS - 1)
                              : 6'(`FLBC_DATA_TRIBITS))) begin
            state_q <= ST_IDLE;
            bfree_q <= 1'b1;
          end
        end
        ST_SEARCH: begin
          if (i_sym_stb && {win_q[45:0], rx_dibit} == SYNC_PATTN) begin
            state_q <= ST_IDLE;
            bfree_q <= 1'b1;
          end
        end
        ST_GATHER: begin
          if (i_sym_stb && seq_k_q == need - 7'h01) begin
            state_q <= ST_DEC;
            cnt_q   <= 6'h00;
          end
        end
        ST_DEC: begin
          cnt_q <= cnt_q + 6'h01;
          if (cnt_q == (raw_q ? 6'(`FLBC_RAW_PAIRS - 1)
                              : 6'(`FLBC_DATA_TRIBITS)))
            state_q <= ST_CRC;
        end
      endcase
    end
  end

  // ****************************************
  // Interleave position
  // ****************************************
  // Column-wise read of a row-wise written 6 by 11 array
  assign pos = (raw_q || !ctl_q[`FLBC_CTL_IL]) ? seq_k_q
             : 7'(int'(il_row_q) * `FLBC_IL_COLS + int'(il_col_q));
  assign pos_adv = (sym_en && tx_left_q != 7'h00)
                 || (state_q == ST_GATHER && i_sym_stb);

  always_ff @(posedge i_clk) begin
    if (i_srst || task_go || (state_q == ST_ENC && cnt_q == 6'h00)) begin
      il_row_q <= 3'h0;
      il_col_q <= 4'h0;
      seq_k_q  <= 7'h00;
    end else if (pos_adv) begin
      seq_k_q <= seq_k_q + 7'h01;
      if (il_row_q == 3'(`FLBC_IL_ROWS - 1)) begin
        il_row_q <= 3'h0;
        il_col_q <= il_col_q + 4'h1;
      end else begin
        il_row_q <= il_row_q + 3'h1;
      end
    end
  end

  // ****************************************
  // Encode and decode
  // ****************************************
  assign idx0   = 7'({cnt_q, 1'b0});
  assign idx1   = 7'({cnt_q, 1'b1});
  // Final tri-bit is zero to flush the trellis
  assign tribit = (cnt_q < 6'(`FLBC_DATA_TRIBITS))
                ? buf_bits[95 - 3*int'(cnt_q) -: 3] : 3'h0;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      for (int i = 0; i < `FLBC_FEC_SYMS; i++)
        sym_q[i] <= 2'h0;
    end else if (state_q == ST_ENC) begin
      if (raw_q) begin
        sym_q[idx0] <= buf_bits[95 - 4*int'(cnt_q) -: 2];
        sym_q[idx1] <= buf_bits[93 - 4*int'(cnt_q) -: 2];
      end else begin
        sym_q[idx0] <= tribit[2:1];
        sym_q[idx1] <= {tribit[0], ^tribit ^ trel_q[0]};
      end
    end else if (state_q == ST_GATHER && i_sym_stb) begin
      sym_q[pos] <= rx_dibit;
    end
  end

  // Trellis state, decoded bits and parity slips
  always_ff @(posedge i_clk) begin
    if (i_srst || task_go) begin
      trel_q     <= 3'h0;
      dec_bits_q <= 96'h0;
      if (i_srst || !tx_mode)
        dq_q <= 8'h00;
    end else if (state_q == ST_ENC && !raw_q) begin
      trel_q <= tribit;
    end else if (state_q == ST_DEC) begin
      if (raw_q)
        dec_bits_q <= {dec_bits_q[91:0], sym_q[idx0], sym_q[idx1]};
      else if (cnt_q < 6'(`FLBC_DATA_TRIBITS))
        dec_bits_q <= {dec_bits_q[92:0], sym_q[idx0],
                       sym_q[idx1][1]};
      if (!raw_q) begin
        trel_q <= {sym_q[idx0], sym_q[idx1][1]};
        if ((^sym_q[idx0] ^ sym_q[idx1][1] ^ trel_q[0] ^ sym_q[idx1][0])
            && dq_q != `FLBC_DQ_MAX)
          dq_q <= dq_q + 8'h01;
      end
    end
  end

  // ****************************************
  // Buffer and CRC state
  // ****************************************
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      for (int i = 0; i < `FLBC_BLK_BYTES; i++)
        buf_q[i] <= 8'h00;
      acc_q     <= `FLBC_CRC_INIT;
      crc_err_q <= 1'b0;
    end else if (task_go && wtask == `FLBC_TASK_RESET) begin
      acc_q     <= `FLBC_CRC_INIT;
      crc_err_q <= 1'b0;
    end else if (data_wr) begin
      buf_q[hptr_q] <= i_data;
    end else if (state_q == ST_CRC && tx_mode && tx_left_q == 7'h00) begin
      unique case (task_q)
        `FLBC_TASK_HDR: begin
          {buf_q[10], buf_q[11]} <= crc_hdr;
        end
        `FLBC_TASK_INT: acc_q <= crc_run12;
        `FLBC_TASK_LAST: begin
          {buf_q[10], buf_q[11]} <= crc_run10;
          acc_q <= `FLBC_CRC_INIT;
        end
        default: ;
      endcase
    end else if (state_q == ST_CRC && !tx_mode) begin
      for (int i = 0; i < `FLBC_BLK_BYTES; i++)
        buf_q[i] <= dec_bits_q[95-8*i -: 8];
      unique case (task_q)
        `FLBC_TASK_HDR:  crc_err_q <= crc_hdr != dec_bits_q[15:0];
        `FLBC_TASK_INT: begin
          acc_q     <= crc_run12;
          crc_err_q <= 1'b0;
        end
        `FLBC_TASK_LAST: begin
          crc_err_q <= crc_run10 != dec_bits_q[15:0];
          acc_q     <= `FLBC_CRC_INIT;
        end
        default: crc_err_q <= 1'b0;
      endcase
    end
  end

  // ****************************************
  // Frame sync search
  // ****************************************
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      win_q  <= 48'h0;
      sync_q <= 1'b0;
    end else begin
      if (!tx_mode && i_sym_stb)
        win_q <= {win_q[45:0], rx_dibit};
      if (task_go && wtask == `FLBC_TASK_SEARCH)
        sync_q <= 1'b0;
      else if (state_q == ST_SEARCH && i_sym_stb
               && {win_q[45:0], rx_dibit} == SYNC_PATTN)
        sync_q <= 1'b1;
    end
  end

  // ****************************************
  // Symbol timing and output
  // ****************************************
  // Divider runs only when sending, so receive draws no symbol ticks
  assign sym_en = tx_mode && div_cnt_q == 16'(SYM_DIV - 1);

  always_ff @(posedge i_clk) begin
    if (i_srst || !tx_mode || sym_en)
      div_cnt_q <= 16'h0000;
    else
      div_cnt_q <= div_cnt_q + 16'h0001;
  end

  always_ff @(posedge i_clk) begin
    if (i_srst || (task_go && wtask == `FLBC_TASK_RESET)) begin
      tx_left_q <= 7'h00;
      o_sym_stb <= 1'b0;
      o_sym_lvl <= LVL_M1;
    end else begin
      o_sym_stb <= 1'b0;
      if (state_q == ST_ENC && cnt_q == (raw_q ? 6'(`FLBC_RAW_PAIRS - 1)
                                               : 6'(`FLBC_DATA_TRIBITS)))
        tx_left_q <= need;
      else if (sym_en && tx_left_q != 7'h00) begin
        tx_left_q <= tx_left_q - 7'h01;
        o_sym_stb <= 1'b1;
        o_sym_lvl <= tx_lvl;
      end
    end
  end

  assign o_tx_active = tx_mode && (tx_left_q != 7'h00
                       || state_q == ST_ENC || state_q == ST_CRC);

  flbc_symmap u_tx_map (
    .i_dibit (sym_q[pos]),
    .o_lvl   (tx_lvl),
    .i_lvl   (LVL_M1),
    .o_dibit ()
  );

  flbc_symmap u_rx_map (
    .i_dibit (2'h0),
    .o_lvl   (),
    .i_lvl   (flbc_lvl_t'(i_sym_lvl)),
    .o_dibit (rx_dibit)
  );

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  AST_MAP_M3: assert property (
    (sym_en && tx_left_q != 7'h00 && sym_q[pos] == 2'h1)
    |=> o_sym_stb && o_sym_lvl == LVL_M3)
    else $error("pair 01 not sent as -3");
  AST_RAW_LEN: assert property (
    (state_q == ST_ENC && raw_q && $past(state_q) != ST_ENC)
    |-> ##24 tx_left_q == 7'd48)
    else $error("raw block not 48 symbols");
  AST_FEC_LEN: assert property (
    (state_q == ST_ENC && !raw_q && $past(state_q) != ST_ENC)
    |-> ##33 tx_left_q == 7'd66)
    else $error("coded block not 66 symbols");
  AST_FLUSH: assert property (
    (state_q == ST_ENC && !raw_q && cnt_q == 6'd32) |-> tribit == 3'h0)
    else $error("flush tri-bit not zero");
  AST_BUSY: assert property (
    (task_go && wtask != `FLBC_TASK_RESET && wtask != `FLBC_TASK_SEARCH)
    |=> !bfree_q)
    else $error("buffer still free after task");
  AST_RX_NOWR: assert property (
    (wr_go && i_addr == `FLBC_SEL_DATA && !tx_mode && state_q == ST_IDLE)
    |=> $stable(hptr_q))
    else $error("write accepted in receive");
  AST_SYNC: assert property (
    (state_q == ST_SEARCH && i_sym_stb && !task_go
     && {win_q[45:0], rx_dibit} == SYNC_PATTN)
    |=> sync_q && bfree_q && state_q == ST_IDLE)
    else $error("sync match not reported");
  AST_HDR_CRC: assert property (
    (state_q == ST_CRC && tx_mode && tx_left_q == 7'h00
     && task_q == `FLBC_TASK_HDR && !task_go)
    |=> {buf_q[10], buf_q[11]} == $past(crc_hdr))
    else $error("header CRC not placed");
  AST_GATHER: assert property (
    (state_q == ST_GATHER && i_sym_stb && !raw_q && seq_k_q == 7'd65
     && !task_go) |=> state_q == ST_DEC ##33 state_q == ST_CRC)
    else $error("decode not after 66 symbols");

endmodule

// [test/flbc_host.sv]
// Purpose: Host microcontroller model on the parallel port.
// Assumes: Access taken on the first edge with strobe low.
// Notes:   Released data bus shows the inverse of its last value.
module flbc_host (
  // Clock
  input  wire logic       i_clk,
  // Port to device
  output logic            o_cs_n,
  output logic            o_rd_n,
  output logic            o_wr_n,
  output logic      [1:0] o_addr,
  output logic      [7:0] o_data,
  input  wire logic [7:0] i_data,
  input  wire logic       i_data_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_cs_n = 1'b1;
    o_rd_n = 1'b1;
    o_wr_n = 1'b1;
    o_addr = 2'h0;
    o_data = 8'h00;
  end
  // Strobe returns high at the take edge, so one idle cycle between calls
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_cs_n <= 1'b0;
    o_wr_n <= 1'b0;
    o_addr <= a;
    o_data <= d;
    @(posedge i_clk);
    o_cs_n <= 1'b1;
    o_wr_n <= 1'b1;
    o_data <= ~d;
  endtask
  // Returns {output enable, read data}
  task automatic rd(input logic [1:0] a, output logic [8:0] q);
    @(posedge i_clk);
    o_cs_n <= 1'b0;
    o_rd_n <= 1'b0;
    o_addr <= a;
    repeat (2) @(posedge i_clk);
    q = {i_data_oe, i_data};
    o_cs_n <= 1'b1;
    o_rd_n <= 1'b1;
  endtask
endmodule

// [test/flbc_core_tb.sv]
// Purpose: Self-checking bench of the four-level block codec.
// Assumes: Short symbol divider; host model drives the parallel port.
// Notes:   Coded path judged by loopback and the CRC bytes.
`include "flbc_params.svh"
module flbc_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int          DIV  = 4;
  localparam logic [47:0] SYNC = 48'h0123_4567_89AB;
  logic       clk = 1'b0;
  logic       srst = 1'b1;
  logic       rx_stb = 1'b0;
  logic [1:0] rx_lvl = 2'h0;
  logic       cs_n, rd_n, wr_n, oe, tx_stb, tx_act, seen_act;
  logic [1:0] addr, tx_lvl;
  logic [7:0] wdat, rdat;
  logic [1:0] cap[$];
  logic [1:0] sy[$];
  logic [8:0] st;
  int         err_total = 0;
  int         num_checks = 0;
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    if (tx_stb === 1'b1) begin
      cap.push_back(tx_lvl);
    end
  end
  flbc_host i_host (.i_clk(clk), .o_cs_n(cs_n), .o_rd_n(rd_n),
    .o_wr_n(wr_n), .o_addr(addr), .o_data(wdat), .i_data(rdat),
    .i_data_oe(oe));
  flbc_core #(.SYM_DIV(DIV), .SYNC_PATTN(SYNC)) i_dut (.i_clk(clk),
    .i_srst(srst), .i_cs_n(cs_n), .i_rd_n(rd_n), .i_wr_n(wr_n),
    .i_addr(addr), .i_data(wdat), .o_data(rdat), .o_data_oe(oe),
    .o_sym_lvl(tx_lvl), .o_sym_stb(tx_stb), .o_tx_active(tx_act),
    .i_sym_lvl(rx_lvl), .i_sym_stb(rx_stb));
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [8:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  function automatic logic [7:0] pat(input int i);
    return 8'h1B + 8'(i) * 8'h35;
  endfunction
  function automatic logic [1:0] lv(input logic [1:0] p);
    return {p[1], ~(p[1] ^ p[0])};
  endfunction
  // CRC over n pattern bytes starting at pattern index o
  function automatic logic [15:0] crc16(input int o, input int n);
    logic [15:0] c;
    logic [7:0]  b;
    c = `FLBC_CRC_INIT;
    for (int i = 0; i < n; i++) begin
      b = pat(o + i);
      for (int j = 7; j >= 0; j--)
        c = {c[14:0], 1'b0} ^ ((c[15] ^ b[j]) ? `FLBC_CRC_POLY : 16'h0000);
    end
    return c;
  endfunction
  task automatic send(input logic [1:0] s);
    @(posedge clk);
    rx_lvl <= s;
    rx_stb <= 1'b1;
    @(posedge clk);
    rx_stb <= 1'b0;
    rx_lvl <= ~s;
    repeat (2) @(posedge clk);
  endtask
  task automatic wait_free;
    int n;
    n = 0;
    do begin
      i_host.rd(`FLBC_SEL_CMD, st);
      n++;
    end while (st[7] !== 1'b1 && n < 400);
    if (st[7] !== 1'b1) begin
      err_total++;
      test_done();
    end
  endtask
  // Hang guard on the symbol stream, also notes the active flag
  task automatic wait_syms(input int n);
    int k;
    k = 0;
    seen_act = 1'b0;
    while (cap.size() < n && k < 3000) begin
      @(posedge clk);
      seen_act |= tx_act;
      k++;
    end
    if (k >= 3000) begin
      err_total++;
      test_done();
    end
    repeat (3 * DIV) @(posedge clk);
    chk("tx_active", {8'h00, seen_act}, 9'h001);
    chk("sym_count", 9'(cap.size()), 9'(n));
  endtask
  task automatic load_tx(input int o, input logic [2:0] tk);
    i_host.wr(`FLBC_SEL_MODE, 8'h01);
    for (int i = 0; i < 12; i++)
      i_host.wr(`FLBC_SEL_DATA, pat(i + o));
    cap.delete();
    i_host.wr(`FLBC_SEL_CMD, {5'h00, tk});
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    i_host.rd(`FLBC_SEL_CMD, st);
    chk("status", st, 9'h180);
    i_host.rd(`FLBC_SEL_CTL, st);
    chk("sel3_read", st, 9'h100);
    $display("reset test done");
  endtask
  task automatic t_raw_tx;
    load_tx(0, `FLBC_TASK_RAW);
    i_host.rd(`FLBC_SEL_DATA, st);
    chk("tx_read", st, 9'h100);
    wait_syms(48);
    for (int i = 0; i < 48; i++)
      chk("tx_sym", 9'(cap[i]), 9'(lv(pat(i / 4) >> (6 - 2 * (i % 4)))));
    $display("raw tx test done");
  endtask
  task automatic t_search;
    i_host.wr(`FLBC_SEL_MODE, 8'h00);
    i_host.wr(`FLBC_SEL_CMD, {5'h00, `FLBC_TASK_SEARCH});
    send(2'h2);
    for (int k = 0; k < 24; k++)
      send(lv(SYNC[47 - 2 * k -: 2]));
    wait_free();
    chk("sync_found", {8'h00, st[5]}, 9'h001);
    $display("search test done");
  endtask
  task automatic t_raw_rx;
    i_host.wr(`FLBC_SEL_CMD, {5'h00, `FLBC_TASK_RAW});
    for (int i = 0; i < 48; i++)
      send(lv(pat(i / 4) >> (6 - 2 * (i % 4))));
    wait_free();
    i_host.wr(`FLBC_SEL_DATA, 8'h5A);
    for (int i = 0; i < 12; i++) begin
      i_host.rd(`FLBC_SEL_DATA, st);
      chk("rx_byte", st, {1'b1, pat(i)});
    end
    $display("raw rx test done");
  endtask
  // Ten data bytes, then CRC of pattern bytes s..s+n-1, high byte first
  task automatic rd_blk(input int o, input int s, input int n);
    logic [7:0] ev;
    for (int i = 0; i < 12; i++) begin
      i_host.rd(`FLBC_SEL_DATA, st);
      ev = (i < 10) ? pat(o + i) : 8'(crc16(s, n) >> (i == 10 ? 8 : 0));
      chk("rx_block_byte", st, {1'b1, ev});
    end
  endtask
  // One coded block fed back from sy; bad slips the first level by one
  task automatic rx_blk(input logic [2:0] tk, input int s0, input bit bad);
    i_host.wr(`FLBC_SEL_CMD, {5'h00, tk});
    for (int j = 0; j < 66; j++)
      send((bad && j == 0) ? sy[s0] ^ 2'h1 : sy[s0 + j]);
    wait_free();
  endtask
  // Coded header sent, then fed back; second pass slips one symbol
  task automatic t_fec;
    load_tx(3, `FLBC_TASK_HDR);
    wait_syms(66);
    sy = cap;
    i_host.wr(`FLBC_SEL_MODE, 8'h00);
    for (int b = 0; b < 2; b++) begin
      rx_blk(`FLBC_TASK_HDR, 0, b == 1);
      chk("crc_error", {8'h00, st[6]}, 9'(b));
      i_host.rd(`FLBC_SEL_MODE, st);
      chk("dq_count", st, {1'b1, 8'(b)});
      if (b == 0)
        rd_blk(3, 3, 10);
    end
    $display("fec test done");
  endtask
  // Intermediate then last block; one running CRC closes the last
  task automatic t_chain;
    load_tx(5, `FLBC_TASK_INT);
    wait_syms(66);
    sy = cap;
    load_tx(17, `FLBC_TASK_LAST);
    wait_syms(66);
    sy = {sy, cap};
    i_host.wr(`FLBC_SEL_MODE, 8'h00);
    rx_blk(`FLBC_TASK_INT, 0, 1'b0);
    rx_blk(`FLBC_TASK_LAST, 66, 1'b0);
    chk("chain_crc_error", {8'h00, st[6]}, 9'h000);
    rd_blk(17, 5, 22);
    $display("chain test done");
  endtask
  initial begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_raw_tx();
    t_search();
    t_raw_rx();
    t_fec();
    t_chain();
    test_done();
  end
endmodule
